// File: design/idf_pkg.sv
// Package for the diagnostic flag and angular-rate output register block.
// Assumes a 100 MHz internal sample clock and a 16-bit framed serial port.
package idf_pkg;

  // ----------------------------------------------------------------------
  // Register addresses (7-bit, as carried in the command word)
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_DIAG_FLAGS = 7'h02;
  localparam logic [6:0] ADDR_RATE_BASE = 7'h04;
  localparam logic [6:0] ADDR_RATE_STRIDE = 7'h04;
  localparam logic [6:0] ADDR_HIGH_OFS = 7'h02;

  // ----------------------------------------------------------------------
  // Diagnostic flag bit positions
  // ----------------------------------------------------------------------
  localparam int FLG_CLK_ERR = 7;
  localparam int FLG_MEM_FAIL = 6;
  localparam int FLG_SENSOR_FAIL = 5;
  localparam int FLG_STANDBY = 4;
  localparam int FLG_SPI_ERR = 3;
  localparam int FLG_FLASH_FAIL = 2;
  localparam int FLG_OVERRUN = 1;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] FLAGS_LIVE_MASK = 8'hFE;

  // ----------------------------------------------------------------------
  // Modes, framing, reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] SYNC_MODE_SCALED = 3'h2;
  localparam logic [3:0] FRAME_CNT_LAST = 4'hF;
  localparam logic [3:0] PIN_RST = 4'h3;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [31:0] RATE_RST = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int MCLK_KHZ = 100_000;
  localparam int SUPPLY_OK_MS = 250;
  localparam int RECOVER_CYC_DFLT = SUPPLY_OK_MS * MCLK_KHZ;

  // ----------------------------------------------------------------------
  // Range variants: raw rate arrives in the finest unit, 1/(160*2^16) dps
  // ----------------------------------------------------------------------
  localparam int RANGE_125 = 0;
  localparam int RANGE_500 = 1;
  localparam int RANGE_2000 = 2;
  localparam int NUM_AXES = 3;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_STANDBY,
    ST_RECOVER
  } idf_pwr_st_t;

  // Same-clock event inputs from the sensor core
  typedef struct packed {
    logic sync_lock_fail;
    logic mem_test_done;
    logic mem_crc_match;
    logic self_test_done;
    logic sensor_fail;
    logic flash_upd_done;
    logic flash_upd_ok;
    logic overrun;
  } idf_evt_t;

  // Divide-by shift that maps the finest unit onto a variant's scale
  function automatic int idf_range_shift(input int range_sel);
    case (range_sel)
      RANGE_500: return 2;
      RANGE_2000: return 4;
      default: return 0;
    endcase
  endfunction

endpackage

// File: design/idf_regs.sv
// Diagnostic flag register and rate output registers behind a 16-bit serial port.
// Assumes the serial pins and supply comparator are asynchronous to i_mclk,
// and that event inputs come from logic on i_mclk.
//
// Functional notes
// R1 - Clock error flag when scaled sync unlocks
// R2 - Memory failure flag on CRC mismatch
// R3 - Sensor failure flag after failed self test
// R4 - Standby flag, halt, resume after 250 ms
// R5 - Serial error when clocks not multiple 16
// R6 - Host repeats sequence on serial error
// R7 - Flash update failure flag on failed update
// R8 - Overrun flag; cause cleared only by reset
// R9 - Reading flags returns them, then clears
// R10 - Flags stay set until read
// R11 - Persisting cause sets flag again
// R12 - Rate is 32-bit, high and low words
// R13 - Zero rate reads zero, one count scaled
// R14 - Scale 160, 40 or 10 by variant
// R15 - Low word holds extra resolution bits
// R16 - X low at 0x04, high at 0x06
// R17 - Same format for y and z axes
// R18 - Reserved flag bits always read zero
// R19 - Both words updated from one sample
`timescale 1ns/1ps

module idf_regs
  import idf_pkg::*;
#(
  parameter int RANGE_SEL = RANGE_125,
  parameter int P_RECOVER_CYC = RECOVER_CYC_DFLT
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Serial port pins
  input wire logic i_cs_b,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe_b,
  // Sensor core events and controls
  input wire idf_evt_t i_evt,
  input wire logic [2:0] i_sync_mode,
  input wire logic i_soft_rst,
  input wire logic i_supply_low,
  // Raw rate samples
  input wire logic i_sample_valid,
  input wire logic [NUM_AXES-1:0][31:0] i_rate_raw,
  // Power state
  output logic o_data_halt,
  output logic o_reinit
);

  localparam int SHIFT = idf_range_shift(RANGE_SEL);
  localparam int CW = $clog2(P_RECOVER_CYC + 1);

  if (RANGE_SEL < RANGE_125 || RANGE_SEL > RANGE_2000) begin : g_bad_range
    $error("RANGE_SEL out of range");
  end
  if (P_RECOVER_CYC < 1) begin : g_bad_recover
    $error("P_RECOVER_CYC must be at least 1");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  logic [3:0] pin_in;
  logic [3:0] s1_r, s2_r, s3_r, filt_r;
  logic [3:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;

  assign pin_in = {i_supply_low, i_mosi, i_sclk, i_cs_b};

  always_comb begin
    s1_nxt = pin_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    for (int k = 0; k < 4; k++) begin
      filt_nxt[k] = (s2_r[k] == s3_r[k]) ? s3_r[k] : filt_r[k];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r <= PIN_RST;
      s2_r <= PIN_RST;
      s3_r <= PIN_RST;
      filt_r <= PIN_RST;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      filt_r <= filt_nxt;
    end
  end

  logic cs_b_f, sclk_f, mosi_f, supply_low_f;
  logic cs_b_d_r, sclk_d_r;
  assign cs_b_f = filt_r[0];
  assign sclk_f = filt_r[1];
  assign mosi_f = filt_r[2];
  assign supply_low_f = filt_r[3];

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_b_d_r <= 1'b1;
      sclk_d_r <= 1'b1;
    end else begin
      cs_b_d_r <= cs_b_f;
      sclk_d_r <= sclk_f;
    end
  end

  logic sel, sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sel = !cs_b_f;
  assign sclk_rise = sel && sclk_f && !sclk_d_r;
  assign sclk_fall = sel && !sclk_f && sclk_d_r;
  assign cs_fall = !cs_b_f && cs_b_d_r;
  assign cs_rise = cs_b_f && !cs_b_d_r;

  // ----------------------------------------------------------------------
  // Rate output words
  // ----------------------------------------------------------------------
  logic [NUM_AXES-1:0][31:0] rate_r, rate_nxt;
  logic halt_r;

  // One capture writes both words, so a host that reads low then high
  // between samples always sees a coherent pair.
  generate
    for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
      always_comb begin
        rate_nxt[a] = rate_r[a];
        if (i_sample_valid && !halt_r) begin
          rate_nxt[a] = 32'($signed(i_rate_raw[a]) >>> SHIFT); // R12 R13 R14 R15 R17 R19
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rate_r <= '0;
    end else begin
      rate_r <= rate_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Serial port: mode 3, 16-bit frames, read data returned on next frame
  // ----------------------------------------------------------------------
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic miso_r, miso_nxt, oe_b_r, oe_b_nxt;
  logic [15:0] cmd, rd_data;
  logic diag_read, spi_err;
  logic [7:0] flags_r, flags_nxt;

  assign cmd = {rx_r[14:0], mosi_f};

  always_comb begin
    rd_data = WORD_RST;
    if (cmd[14:8] == ADDR_DIAG_FLAGS) begin
      rd_data = {8'h00, flags_r & FLAGS_LIVE_MASK}; // R18
    end
    for (int a = 0; a < NUM_AXES; a++) begin
      if (cmd[14:8] == 7'(ADDR_RATE_BASE + 7'(a) * ADDR_RATE_STRIDE)) begin
        rd_data = rate_r[a][15:0]; // R16
      end
      if (cmd[14:8] == 7'(ADDR_RATE_BASE + 7'(a) * ADDR_RATE_STRIDE + ADDR_HIGH_OFS)) begin
        rd_data = rate_r[a][31:16]; // R16
      end
    end
  end

  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    miso_nxt = miso_r;
    oe_b_nxt = cs_b_f;
    diag_read = 1'b0;
    spi_err = 1'b0;
    if (cs_fall) begin
      bit_cnt_nxt = 4'h0;
      miso_nxt = tx_r[15];
    end
    if (sclk_rise) begin
      rx_nxt = cmd;
      bit_cnt_nxt = bit_cnt_r + 4'h1;
      tx_nxt = {tx_r[14:0], 1'b0};
      if (bit_cnt_r == FRAME_CNT_LAST) begin
        // Writes have no target here; only reads load the reply
        if (!cmd[15]) begin
          tx_nxt = rd_data;
          diag_read = (cmd[14:8] == ADDR_DIAG_FLAGS);
        end else begin
          tx_nxt = WORD_RST;
        end
      end
    end
    if (sclk_fall) begin
      miso_nxt = tx_r[15];
    end
    if (cs_rise && bit_cnt_r != 4'h0) begin
      spi_err = 1'b1; // R5
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt_r <= 4'h0;
      rx_r <= WORD_RST;
      tx_r <= WORD_RST;
      miso_r <= 1'b0;
      oe_b_r <= 1'b1;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      miso_r <= miso_nxt;
      oe_b_r <= oe_b_nxt;
    end
  end

  assign o_miso = miso_r;
  assign o_miso_oe_b = oe_b_r;

  // ----------------------------------------------------------------------
  // Supply monitor: halt below threshold, resume after a stable interval
  // ----------------------------------------------------------------------
  idf_pwr_st_t pwr_st_r, pwr_st_nxt;
  logic [CW-1:0] rec_cnt_r, rec_cnt_nxt;
  logic halt_nxt, reinit_r, reinit_nxt;

  always_comb begin
    pwr_st_nxt = pwr_st_r;
    rec_cnt_nxt = rec_cnt_r;
    reinit_nxt = 1'b0;
    unique case (pwr_st_r)
      ST_RUN: begin
        if (supply_low_f) begin
          pwr_st_nxt = ST_STANDBY; // R4
        end
      end
      ST_STANDBY: begin
        rec_cnt_nxt = '0;
        if (!supply_low_f) begin
          pwr_st_nxt = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        rec_cnt_nxt = rec_cnt_r + CW'(1);
        if (supply_low_f) begin
          pwr_st_nxt = ST_STANDBY;
        end else if (rec_cnt_r == CW'(P_RECOVER_CYC - 1)) begin
          pwr_st_nxt = ST_RUN; // R4
          reinit_nxt = 1'b1;
        end
      end
    endcase
    halt_nxt = (pwr_st_nxt != ST_RUN);
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_st_r <= ST_RUN;
      rec_cnt_r <= '0;
      halt_r <= 1'b0;
      reinit_r <= 1'b0;
    end else begin
      pwr_st_r <= pwr_st_nxt;
      rec_cnt_r <= rec_cnt_nxt;
      halt_r <= halt_nxt;
      reinit_r <= reinit_nxt;
    end
  end

  assign o_data_halt = halt_r;
  assign o_reinit = reinit_r;

  // ----------------------------------------------------------------------
  // Diagnostic flags: sticky, clear on read, set beats clear
  // ----------------------------------------------------------------------
  logic ovr_hold_r, ovr_hold_nxt;
  logic [7:0] cause;

  always_comb begin
    cause = FLAGS_RST;
    cause[FLG_CLK_ERR] = i_evt.sync_lock_fail && (i_sync_mode == SYNC_MODE_SCALED); // R1
    cause[FLG_MEM_FAIL] = i_evt.mem_test_done && !i_evt.mem_crc_match; // R2
    cause[FLG_SENSOR_FAIL] = i_evt.self_test_done && i_evt.sensor_fail; // R3
    cause[FLG_STANDBY] = supply_low_f; // R4
    cause[FLG_SPI_ERR] = spi_err; // R5
    cause[FLG_FLASH_FAIL] = i_evt.flash_upd_done && !i_evt.flash_upd_ok; // R7
    cause[FLG_OVERRUN] = ovr_hold_r || i_evt.overrun; // R8
    // Overrun cause outlives reads; only a reset drops it
    ovr_hold_nxt = i_soft_rst ? 1'b0 : (ovr_hold_r || i_evt.overrun); // R8
    flags_nxt = flags_r;
    if (diag_read) begin
      flags_nxt = FLAGS_RST; // R9
    end
    flags_nxt = (flags_nxt | cause) & FLAGS_LIVE_MASK; // R10 R11 R18
    if (i_soft_rst) begin
      flags_nxt = FLAGS_RST;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_r <= FLAGS_RST;
      ovr_hold_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      ovr_hold_r <= ovr_hold_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_clk_err_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R1
    (i_evt.sync_lock_fail && i_sync_mode == SYNC_MODE_SCALED && !i_soft_rst) |=> flags_r[FLG_CLK_ERR])
    else $error("clock error flag not set");

  chk_mem_fail_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R2
    (i_evt.mem_test_done && !i_evt.mem_crc_match && !i_soft_rst) |=> flags_r[FLG_MEM_FAIL])
    else $error("memory failure flag not set");

  chk_sensor_fail_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R3
    (i_evt.self_test_done && i_evt.sensor_fail && !i_soft_rst) |=> flags_r[FLG_SENSOR_FAIL])
    else $error("sensor failure flag not set");

  chk_standby_halt: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R4
    supply_low_f |=> ##1 o_data_halt && $stable(rate_r))
    else $error("data not halted in standby");

  chk_spi_err_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R5
    (cs_rise && bit_cnt_r != 4'h0 && !i_soft_rst) |=> flags_r[FLG_SPI_ERR])
    else $error("serial error flag not set");

  chk_flash_fail_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R7
    (i_evt.flash_upd_done && !i_evt.flash_upd_ok && !i_soft_rst) |=> flags_r[FLG_FLASH_FAIL])
    else $error("flash failure flag not set");

  chk_overrun_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R8
    (flags_r[FLG_OVERRUN] && !i_soft_rst) |=> flags_r[FLG_OVERRUN])
    else $error("overrun dropped without reset");

  chk_read_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R9
    (diag_read && cause == FLAGS_RST) |=> flags_r == FLAGS_RST && tx_r[7:0] == $past(flags_r))
    else $error("flag read did not return and clear");

  chk_flags_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R10
    (!diag_read && !i_soft_rst) |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("flag dropped without read");

  chk_reserved_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R18
    diag_read |=> (tx_r[15:8] == 8'h00) && !tx_r[0] && !flags_r[0])
    else $error("reserved flag bit set");

  chk_rate_pair: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R19
    (i_sample_valid && !halt_r) |=> rate_r[0] == 32'($signed($past(i_rate_raw[0])) >>> SHIFT))
    else $error("rate word pair not captured together");

endmodule // idf_regs

// File: testbench/idf_spi_host.sv
// Host model that reads the register block over the framed 16-bit serial port.
// Assumes the block samples its pins with i_mclk; sclk idles high between frames.
`timescale 1ns/1ps

module idf_spi_host (
  // Clock
  input wire logic i_mclk,
  // Serial pins
  input wire logic i_miso,
  output logic o_cs_b,
  output logic o_sclk,
  output logic o_mosi
);
  initial begin
    o_cs_b = 1'b1;
    o_sclk = 1'b1;
    o_mosi = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // ----------------------------------------------------------------------
  // One frame, MSB first, 80 ns sclk period
  // ----------------------------------------------------------------------
  // Miso is taken at the end of the high phase, well after the reply bit settles
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge i_mclk);
    o_cs_b <= 1'b0;
    wt(6);
    for (int i = 0; i < nbits; i++) begin
      o_sclk <= 1'b0;
      o_mosi <= cmd[15 - (i % 16)];
      wt(4);
      o_sclk <= 1'b1;
      wt(4);
      rx = {rx[14:0], i_miso};
    end
    o_cs_b <= 1'b1;
    // Released data line toggles so a stale level is never mistaken for data
    o_mosi <= ~o_mosi;
    wt(10);
  endtask
endmodule // idf_spi_host

// File: testbench/tb.sv
// Self-checking bench for the diagnostic flag and rate output register block.
// Assumes the host model in idf_spi_host and a 50-cycle recovery count.
`timescale 1ns/1ps

module tb;
  import idf_pkg::*;
  localparam int REC_CYC = 50;
  logic i_mclk, i_rst_b, cs_b, sclk, mosi, miso, miso_oe_b;
  logic soft_rst, supply_low, sample_valid, data_halt, reinit;
  idf_evt_t evt;
  logic [2:0] sync_mode;
  logic [NUM_AXES-1:0][31:0] rate_raw;
  logic [15:0] rx;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] ev_tab [9] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h60, 8'h18, 8'h10, 8'h04, 8'hFC};
  logic [2:0] md_tab [9] = '{3'h2, 3'h0, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2};
  logic [15:0] fl_tab [9] = '{16'h0080, 16'h0000, 16'h0000, 16'h0040, 16'h0000, 16'h0020,
                              16'h0000, 16'h0004, 16'h00A4};

  idf_regs #(.RANGE_SEL(RANGE_125), .P_RECOVER_CYC(REC_CYC)) u_dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_sclk(sclk), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe_b(miso_oe_b), .i_evt(evt), .i_sync_mode(sync_mode),
    .i_soft_rst(soft_rst), .i_supply_low(supply_low), .i_sample_valid(sample_valid),
    .i_rate_raw(rate_raw), .o_data_halt(data_halt), .o_reinit(reinit));

  idf_spi_host u_host (.i_mclk(i_mclk), .i_miso(miso), .o_cs_b(cs_b), .o_sclk(sclk), .o_mosi(mosi));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // ----------------------------------------------------------------------
  // Checks and access tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reply comes in the frame after the command
  task automatic chk_rd(input logic [6:0] addr, input logic [15:0] exp);
    logic [15:0] v;
    u_host.xfer({1'b0, addr, 8'h00}, 16, v);
    u_host.xfer(16'h0000, 16, v);
    cmp16(v, exp);
  endtask

  task automatic pulse_evt(input logic [7:0] e, input logic [2:0] mode);
    @(posedge i_mclk);
    evt <= idf_evt_t'(e);
    sync_mode <= mode;
    @(posedge i_mclk);
    evt <= idf_evt_t'(8'h00);
  endtask

  task automatic sample(input logic [NUM_AXES-1:0][31:0] r);
    @(posedge i_mclk);
    rate_raw <= r;
    sample_valid <= 1'b1;
    @(posedge i_mclk);
    sample_valid <= 1'b0;
  endtask

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0;
    evt = idf_evt_t'(8'h00);
    sync_mode = 3'h0;
    soft_rst = 1'b0;
    supply_low = 1'b0;
    sample_valid = 1'b0;
    rate_raw = '0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (6) @(posedge i_mclk);
    cmp16({13'h0, miso_oe_b, data_halt, reinit}, 16'h0004);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0000);
    for (int k = 0; k < 9; k++) begin
      pulse_evt(ev_tab[k], md_tab[k]);
      chk_rd(ADDR_DIAG_FLAGS, fl_tab[k]);
      chk_rd(ADDR_DIAG_FLAGS, 16'h0000);
    end
    // Rate words for all three axes from one sample
    sample({32'h0001_0000, 32'hFFFF_FFFE, 32'h4E20_1234});
    chk_rd(7'h04, 16'h1234);
    chk_rd(7'h06, 16'h4E20);
    chk_rd(7'h08, 16'hFFFE);
    chk_rd(7'h0A, 16'hFFFF);
    chk_rd(7'h0E, 16'h0001);
    chk_rd(7'h20, 16'h0000);
    // Frame lengths: 15 clocks flag an error, 32 clocks do not
    u_host.xfer(16'h0200, 15, rx);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0008);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0000);
    u_host.xfer(16'h8200, 32, rx);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0000);
    // Overrun stays until a reset of either kind
    pulse_evt(8'h01, 3'h0);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0002);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0002);
    @(posedge i_mclk);
    soft_rst <= 1'b1;
    @(posedge i_mclk);
    soft_rst <= 1'b0;
    chk_rd(ADDR_DIAG_FLAGS, 16'h0000);
    pulse_evt(8'h01, 3'h0);
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (6) @(posedge i_mclk);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0000);
    // Standby: samples ignored, flag re-set while supply low
    sample({32'h0, 32'h0, 32'h4E20_1234});
    @(posedge i_mclk);
    supply_low <= 1'b1;
    repeat (8) @(posedge i_mclk);
    cmp16({15'h0, data_halt}, 16'h0001);
    sample({32'h0, 32'h0, 32'h7FFF_0000});
    chk_rd(7'h06, 16'h4E20);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0010);
    @(posedge i_mclk);
    supply_low <= 1'b0;
    n = 0;
    while (reinit !== 1'b1 && n < 200) begin
      @(posedge i_mclk);
      n++;
    end
    cmp16({15'h0, (n >= REC_CYC && n <= REC_CYC + 8)}, 16'h0001);
    @(posedge i_mclk);
    cmp16({14'h0, data_halt, reinit}, 16'h0000);
    sample({32'h0, 32'h0, 32'h0000_0000});
    chk_rd(7'h06, 16'h0000);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0010);
    chk_rd(ADDR_DIAG_FLAGS, 16'h0000);
    end_sim();
  end
endmodule // tb
